/* File: design/cii_card_init.sv */
// Card-side init and reset sequencer: READY timing, personality change,
// per-channel reset, free flags, reinit request and buffer size registers.
// Assumes a classic Wishbone master and a host keeping its own timings.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Reinit request flag sits at status bit 4 in both channels.
// - A reinit request sets the flag in both channels together.
// - Reinit request flag clears once a reset bit is seen set.
// - No link packets between raising reinit request and seeing reset bit.
// - No link packets until the soft reset sequence has completed.
// - Config option register usable only before the personality change.
// - Writing the config table index switches the card to stream mode.
// - READY goes low within 10 us of reset release unless ready soon.
// - READY rises after internal init, at most 5 s after release.
// - Card switches pins to stream use at least 10 us after config write.
// - Channel reset is set bit, hold 40 us, clear; data then extended.
// - Channel reset flushes buffer, free flag low until ready, then 1.
// - Card buffer 16 bytes minimum, 65535 maximum, per channel sizes.
// - Reset bit on either channel resets the interface of both.
// - Soft reset closes sessions and returns to post-personality state.
module cii_card_init
	import cii_pkg::*;
#(
	parameter int READY_TIMEOUT_CYC = `CII_READY_MAX_S * `CII_US_PER_S * `CII_CLK_MHZ
)
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Card pins
	input wire logic CARD_RESET_IN,
	output logic CARD_READY,
	output logic STREAM_PINS_EN,
	// Card internals
	input wire logic INIT_DONE,
	input wire logic REINIT_REQ,
	input wire logic [1:0] CHAN_READY,
	output logic [1:0] CHAN_FLUSH,
	output logic SESSION_CLOSE,
	output logic LINK_TX_EN
);

	localparam logic [`CII_TMR_W-1:0] PIN_CYC = `CII_TMR_W'(`CII_PIN_SWITCH_US * `CII_CLK_MHZ);
	localparam logic [`CII_TMR_W-1:0] READY_CYC = `CII_TMR_W'(READY_TIMEOUT_CYC);

	cii_state_t s_reg;
	cii_state_t s_next;
	logic rd_start;
	logic rd_done;
	logic sw_start;
	logic sw_done;
	logic req;
	logic wr;
	logic live;
	logic rs_any;
	logic [5:0] idx;

	// State after power-on or a hard card reset
	function automatic cii_state_t init_state();
		cii_state_t t;
		t = '0;
		t.mode = M_HOLD;
		t.size[0] = `CII_CARD_BUF;
		t.size[1] = `CII_CARD_BUF;
		return t;
	endfunction

	// Word index of a channel's control or size register
	function automatic logic [5:0] chan_idx(input int ch, input logic sz);
		logic [5:0] base;
		base = (ch == 0) ? `CII_IDX_DCS : `CII_IDX_ECS;
		return sz ? base + 6'h01 : base;
	endfunction

	// Status byte of one channel
	function automatic logic [31:0] stat_word(input logic fr, input logic reinit_request_flag);
		logic [31:0] w;
		w = '0;
		w[`CII_BIT_FR] = fr;
		w[`CII_BIT_IIR] = reinit_request_flag;
		return w;
	endfunction

	// Timer for the READY deadline after reset release
	cii_delay u_ready_tmr (
		.clk(SYS_CLK),
		.rst(RST),
		.start(rd_start),
		.limit(READY_CYC),
		.done(rd_done)
	);

	// Timer for the pin switch after the config write
	cii_delay u_pin_tmr (
		.clk(SYS_CLK),
		.rst(RST),
		.start(sw_start),
		.limit(PIN_CYC),
		.done(sw_done)
	);

	// Bus decode
	assign req = WB_CYC_I && WB_STB_I;
	assign wr = req && s_reg.ack && WB_WE_I;
	assign idx = WB_ADR_I[7:2];
	assign live = (s_reg.mode == M_STREAM);
	assign rs_any = |s_reg.rs;

	// Next state
	always_comb begin
		logic [15:0] sz;
		sz = '0;
		s_next = s_reg;
		s_next.close = 1'b0;
		rd_start = 1'b0;
		sw_start = 1'b0;
		// Bus answer one cycle after the request is seen
		s_next.ack = req && !s_reg.ack;
		if (req && !s_reg.ack) begin
			case (idx)
				`CII_IDX_DCS: s_next.rdata = stat_word(s_reg.fr[0], s_reg.reinit_request_flag[0]);
				`CII_IDX_ECS: s_next.rdata = stat_word(s_reg.fr[1], s_reg.reinit_request_flag[1]);
				`CII_IDX_DSZ: s_next.rdata = {16'h0000, s_reg.size[0]};
				`CII_IDX_ESZ: s_next.rdata = {16'h0000, s_reg.size[1]};
				`CII_IDX_COR: begin
					// Hidden once the personality has changed
					if (s_reg.mode == M_CARD) begin
						s_next.rdata = {24'h000000, s_reg.config_option_register};
					end else begin
						s_next.rdata = '0;
					end
				end
				`CII_IDX_CST: begin
					s_next.rdata = '0;
					s_next.rdata[`CII_CST_READY] = CARD_READY;
					s_next.rdata[`CII_CST_STREAM] = STREAM_PINS_EN;
					s_next.rdata[`CII_CST_LINK] = s_reg.link_ok;
				end
				default: s_next.rdata = '0;
			endcase
		end
		// Personality sequence
		case (s_reg.mode)
			M_HOLD: begin
				if (!CARD_RESET_IN) begin
					s_next.mode = M_INIT;
					rd_start = 1'b1;
				end
			end
			M_INIT: begin
				// READY stays low here
				if (INIT_DONE || rd_done) begin
					s_next.mode = M_CARD;
				end
			end
			M_CARD: begin
				if (wr && idx == `CII_IDX_COR && WB_SEL_I[0]) begin
					s_next.config_option_register = WB_DAT_I[7:0];
					if (WB_DAT_I[7:0] == `CII_CFG_INDEX) begin
						s_next.mode = M_SWITCH;
						sw_start = 1'b1;
					end
				end
			end
			M_SWITCH: begin
				if (sw_done) begin
					s_next.mode = M_STREAM;
				end
			end
			M_STREAM: begin
			end
			default: s_next.mode = M_HOLD;
		endcase
		// Per-channel registers, live only in stream mode
		for (int i = 0; i < 2; i++) begin
			if (live && wr && idx == chan_idx(i, 1'b0) && WB_SEL_I[0]) begin
				s_next.rs[i] = WB_DAT_I[`CII_BIT_RS];
			end
			sz = s_reg.size[i];
			if (WB_SEL_I[0]) begin
				sz[7:0] = WB_DAT_I[7:0];
			end
			if (WB_SEL_I[1]) begin
				sz[15:8] = WB_DAT_I[15:8];
			end
			if (live && wr && idx == chan_idx(i, 1'b1) && sz >= `CII_BUF_MIN) begin
				s_next.size[i] = sz;
			end
			// Either reset bit clears the free flag and sets the size of both channels back to 256 bytes
			if (rs_any) begin
				s_next.fr[i] = 1'b0;
				s_next.size[i] = `CII_CARD_BUF;
			end else if (live && CHAN_READY[i]) begin
				s_next.fr[i] = 1'b1;
			end
		end
		// Soft reset: close sessions once, hold the link shut
		if (rs_any) begin
			s_next.reinit_request_flag = 2'b00;
			s_next.rs_seen = 1'b1;
			s_next.close = !s_reg.rs_seen;
		end else if (s_reg.rs_seen && &s_reg.fr) begin
			s_next.rs_seen = 1'b0;
			s_next.link_ok = 1'b1;
		end
		if (rs_any || REINIT_REQ || |s_reg.reinit_request_flag) begin
			s_next.link_ok = 1'b0;
		end
		// Raise in both channels; a new request beats the clear
		if (live && REINIT_REQ) begin
			s_next.reinit_request_flag = 2'b11;
		end
		// Hard reset reverts to the plain card personality
		if (CARD_RESET_IN) begin
			s_next = init_state();
		end
	end

	// State register
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			s_reg <= init_state();
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs from the state register
	assign WB_ACK_O = s_reg.ack;
	assign WB_DAT_O = s_reg.rdata;
	assign CARD_READY = (s_reg.mode != M_HOLD) && (s_reg.mode != M_INIT);
	assign STREAM_PINS_EN = live;
	assign CHAN_FLUSH = s_reg.rs;
	assign SESSION_CLOSE = s_reg.close;
	assign LINK_TX_EN = s_reg.link_ok;

	// Cycles spent waiting for the pin switch
	logic [`CII_TMR_W-1:0] sw_age;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sw_age <= '0;
		end else if (s_reg.mode == M_SWITCH) begin
			sw_age <= sw_age + `CII_TMR_W'(1);
		end else begin
			sw_age <= '0;
		end
	end

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	// Checks
	ready_low_a: assert property ($fell(CARD_RESET_IN) |-> !CARD_READY)
		else $error("READY high right after reset release");
	ready_rise_a: assert property ((s_reg.mode == M_INIT && INIT_DONE && !CARD_RESET_IN)
		|=> CARD_READY)
		else $error("READY not raised after init done");
	iir_both_a: assert property ((live && REINIT_REQ && !CARD_RESET_IN)
		|=> s_reg.reinit_request_flag == 2'b11)
		else $error("Reinit request not set in both channels");
	iir_clear_a: assert property ((rs_any && !REINIT_REQ) |=> s_reg.reinit_request_flag == 2'b00)
		else $error("Reinit request not cleared by reset bit");
	no_link_a: assert property (|s_reg.reinit_request_flag |-> !LINK_TX_EN)
		else $error("Link packets allowed while reinit pending");
	link_shut_a: assert property (rs_any |=> !LINK_TX_EN)
		else $error("Link packets allowed during soft reset");
	cor_hidden_a: assert property ((WB_ACK_O && idx == `CII_IDX_COR
		&& $past(s_reg.mode) != M_CARD) |-> WB_DAT_O == '0)
		else $error("Config option register visible after switch");
	cor_switch_a: assert property ((s_reg.mode == M_CARD && wr && idx == `CII_IDX_COR
		&& WB_SEL_I[0] && WB_DAT_I[7:0] == `CII_CFG_INDEX && !CARD_RESET_IN)
		|=> s_reg.mode == M_SWITCH)
		else $error("Config index write did not switch personality");
	pin_delay_a: assert property ($rose(STREAM_PINS_EN) |-> sw_age >= PIN_CYC)
		else $error("Stream pins switched too early");
	fr_low_a: assert property ((s_reg.rs[0] && !CARD_RESET_IN) |=> !s_reg.fr[0])
		else $error("Free flag high during channel reset");
	size_min_a: assert property (s_reg.size[0] >= `CII_BUF_MIN
		&& s_reg.size[1] >= `CII_BUF_MIN)
		else $error("Buffer size below minimum");
	close_a: assert property ($rose(rs_any) && !s_reg.rs_seen |=> SESSION_CLOSE)
		else $error("Sessions not closed on soft reset");
	rs_hold_a: assert property ((s_reg.rs[1] && !wr && !CARD_RESET_IN) |=> s_reg.rs[1])
		else $error("Reset bit dropped without a host write");

	// Main scenarios
	switch_c: cover property ($rose(STREAM_PINS_EN));
	reinit_c: cover property (|s_reg.reinit_request_flag ##[1:50] rs_any);
	link_c: cover property ($rose(LINK_TX_EN));

endmodule // cii_card_init

`default_nettype wire

/* File: design/cii_delay.sv */
// One-shot delay timer: done rises a set number of cycles after start.
// Assumes a single synchronous clock and an active-high async reset.
`timescale 1ns/10ps
`default_nettype none

module cii_delay
	import cii_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic [`CII_TMR_W-1:0] limit,
	// Result
	output logic done
);

	cii_tmr_t t_reg;
	cii_tmr_t t_next;

	// Count from start until the limit, then hold done
	always_comb begin
		t_next = t_reg;
		if (start) begin
			t_next.cnt = `CII_TMR_W'(1);
			t_next.run = 1'b1;
			t_next.done = 1'b0;
		end else if (t_reg.run) begin
			if (t_reg.cnt >= limit) begin
				t_next.run = 1'b0;
				t_next.done = 1'b1;
			end else begin
				t_next.cnt = t_reg.cnt + `CII_TMR_W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign done = t_reg.done;

endmodule // cii_delay

`default_nettype wire

/* File: shared/cii_map.svh */
// Register map, bit positions and timing figures of the card init block.
// Assumes a 100 MHz system clock and a 32-bit Wishbone register bus.
`ifndef CII_MAP_SVH
`define CII_MAP_SVH

// Clock rate and documented delays in their own units
`define CII_CLK_MHZ 100
`define CII_PIN_SWITCH_US 10
`define CII_READY_MAX_S 5
`define CII_US_PER_S 1000000
`define CII_TMR_W 32

// Word indexes (byte address = index * 4)
`define CII_IDX_DCS 6'h00
`define CII_IDX_DSZ 6'h01
`define CII_IDX_ECS 6'h02
`define CII_IDX_ESZ 6'h03
`define CII_IDX_COR 6'h04
`define CII_IDX_CST 6'h05

// Control and status bit positions
`define CII_BIT_FR 6
`define CII_BIT_IIR 4
`define CII_BIT_RS 3
`define CII_CST_READY 0
`define CII_CST_STREAM 1
`define CII_CST_LINK 2

// Buffer sizes in bytes
`define CII_BUF_MIN 16'h0010
`define CII_CARD_BUF 16'h0100

// Config table index the card answers to (arbitrary value)
`define CII_CFG_INDEX 8'h01

`endif

/* File: shared/cii_pkg.sv */
// Types shared by the card init block and its delay timer.
// Assumes cii_map.svh sits on the include path.
`include "cii_map.svh"

package cii_pkg;

	// Personality and reset progress of the card
	typedef enum logic [2:0] {
		M_HOLD,
		M_INIT,
		M_CARD,
		M_SWITCH,
		M_STREAM
	} cii_mode_t;

	// Whole state of the init block
	typedef struct packed {
		cii_mode_t mode;
		logic ack;
		logic [31:0] rdata;
		logic [1:0] rs;
		logic [1:0] reinit_request_flag;
		logic [1:0] fr;
		logic [1:0][15:0] size;
		logic [7:0] config_option_register;
		logic rs_seen;
		logic link_ok;
		logic close;
	} cii_state_t;

	// Whole state of one delay timer
	typedef struct packed {
		logic [`CII_TMR_W-1:0] cnt;
		logic run;
		logic done;
	} cii_tmr_t;

endpackage

/* File: tb/cii_host_model.sv */
// Host controller model: Wishbone master tasks and the card reset pin.
// Assumes the card init block is the only slave, on the same clock.
`timescale 1ns/10ps
`default_nettype none

module cii_host_model #(
	parameter int HARD_CYC = 1000,
	parameter int SETTLE_CYC = 50,
	parameter int HOLD_CYC = 4000
)
(
	// Clock
	input wire logic clk,
	// Wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic ack,
	input wire logic [31:0] rdat,
	// Card reset pin
	output logic card_rst
);
	// Idle bus at time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
		card_rst = 1'b0; // Reset pin left alone at power-up
	end

	// One classic cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		dat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		dat <= ~d; // Stale data not left on the bus
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask

	// Hard reset pulse, then settle before any access
	task automatic hard_reset();
		@(posedge clk);
		card_rst <= 1'b1;
		repeat (HARD_CYC) @(posedge clk);
		card_rst <= 1'b0;
		repeat (SETTLE_CYC) @(posedge clk);
	endtask

	// Channel reset: set bit, hold, clear
	task automatic chan_reset(input logic [7:0] a);
		wr(a, 32'h8);
		repeat (HOLD_CYC) @(posedge clk);
		wr(a, 32'h0);
	endtask
endmodule // cii_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the card init block with a host model.
// Assumes cii_map.svh on the include path and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "cii_map.svh"

module testbench;
	// Design pins and bench state
	logic clk, rst, cyc, stb, we, ack, card_rst, ready, pins;
	logic init_done, reinit, close, link;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [1:0] chan_rdy, flush;
	int errors, n_checks, cycles, n_close, s;
	int msize[2];

	cii_host_model i_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(wdat), .ack(ack), .rdat(rdat), .card_rst(card_rst));

	cii_card_init #(.READY_TIMEOUT_CYC(200)) i_dut (.SYS_CLK(clk), .RST(rst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.CARD_RESET_IN(card_rst), .CARD_READY(ready), .STREAM_PINS_EN(pins),
		.INIT_DONE(init_done), .REINIT_REQ(reinit), .CHAN_READY(chan_rdy),
		.CHAN_FLUSH(flush), .SESSION_CLOSE(close), .LINK_TX_EN(link));

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Timeout and session close pulse count
	always @(posedge clk) begin
		cycles++;
		if (close === 1'b1) n_close++;
		if (cycles == 40000) begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		i_host.rd(a, q);
		chk(nm, e, q);
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h63d058a4));
		rst = 1'b1;
		init_done = 1'b0;
		reinit = 1'b0;
		chan_rdy = 2'b00;
		msize = '{256, 256};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		chk("ready early", 1'b0, ready);
		init_done <= 1'b1;
		repeat (3) @(posedge clk);
		chk("ready", 1'b1, ready);
		$display("test ready done");
		i_host.wr(8'h10, 32'h02);
		rchk("cor before", 8'h10, 32'h02);
		rchk("status card", 8'h14, 32'h1);
		i_host.wr(8'h10, `CII_CFG_INDEX);
		repeat (`CII_PIN_SWITCH_US * `CII_CLK_MHZ - 5) @(posedge clk);
		chk("pins early", 1'b0, pins);
		repeat (10) @(posedge clk);
		chk("pins", 1'b1, pins);
		rchk("cor after", 8'h10, 32'h0);
		rchk("status stream", 8'h14, 32'h3);
		$display("test personality done");
		for (int c = 0; c < 2; c++) begin
			s = 16 + ($urandom % 65520);
			i_host.wr(8'(c * 8 + 4), 32'(s));
			msize[c] = s;
			i_host.wr(8'(c * 8 + 4), 32'h0f);
			rchk("size", 8'(c * 8 + 4), 32'(msize[c]));
		end
		$display("test sizes done");
		chk("link before", 1'b0, link);
		i_host.wr(8'h00, 32'h8);
		msize = '{256, 256};
		repeat (2) @(posedge clk);
		chk("flush", 2'b01, flush);
		rchk("ext free", 8'h08, 32'h0);
		rchk("ext size", 8'h0c, 32'(msize[1]));
		repeat (4000) @(posedge clk);
		chk("flush held", 2'b01, flush);
		chk("close", 1'b1, n_close > 0);
		i_host.wr(8'h00, 32'h0);
		i_host.chan_reset(8'h08);
		chk("link held", 1'b0, link);
		chan_rdy <= 2'b11;
		repeat (3) @(posedge clk);
		chk("link", 1'b1, link);
		rchk("data free", 8'h00, 32'h40);
		rchk("ext free set", 8'h08, 32'h40);
		$display("test soft reset done");
		reinit <= 1'b1;
		@(posedge clk);
		reinit <= 1'b0;
		repeat (2) @(posedge clk);
		chk("link reinit", 1'b0, link);
		rchk("data reinit", 8'h00, 32'h50);
		rchk("ext reinit", 8'h08, 32'h50);
		i_host.wr(8'h00, 32'h8);
		rchk("ext cleared", 8'h08, 32'h0);
		repeat (4000) @(posedge clk);
		i_host.wr(8'h00, 32'h0);
		i_host.chan_reset(8'h08);
		repeat (3) @(posedge clk);
		chk("link again", 1'b1, link);
		rchk("unmapped", 8'hfc, 32'h0);
		$display("test reinit done");
		init_done <= 1'b0;
		i_host.hard_reset();
		chk("ready hard", 1'b0, ready);
		chk("pins hard", 1'b0, pins);
		repeat (200) @(posedge clk);
		chk("ready timeout", 1'b1, ready);
		rchk("status hard", 8'h14, 32'h1);
		$display("test hard reset done");
		summarize();
	end
endmodule // testbench
`default_nettype wire
